//--- logic/psr_pkg.sv
// Function
// R1 - Each peripheral owns a 16 Kbyte window in the upper 3 Mbyte of address space.
// R2 - Interrupt controller window is only 4 Kbyte; the rest of its slot is unmapped.
// R3 - Base is the lowest window address; offsets are decoded from that base.
// R4 - Peripheral registers are reached only over the low-power peripheral bus port.
// R5 - Register set holds control, mode, data, status and interrupt registers.
// R6 - Triplet layout in order: set address, clear address, read address.
// R7 - Ones written to set or clear change that bit; zeros leave it alone.
// R8 - Byte lanes are little-endian: byte enable i carries data bits 8i+7..8i.
// R9 - Set and clear addresses read zero; writes to the read address change nothing.
package psr_pkg;
  // ****************************************
  // Address map
  // ****************************************
  localparam logic [31:0] PSR_REGION_BASE = 32'hFFD00000;
  localparam int PSR_WIN_SHIFT = 14;
  localparam logic [7:0] PSR_WIN_FIRST = 8'h40;
  localparam logic [7:0] PSR_IC_WIN_IDX = 8'hBF;
  localparam logic [19:0] PSR_IC_PAGE = 20'hFFFFF;
  localparam logic [7:0] PSR_SELF_WIN_IDX = 8'h00;
  // ****************************************
  // Triplet layout
  // ****************************************
  localparam int PSR_NREG = 5;
  localparam logic [1:0] PSR_FN_SET = 2'h0;
  localparam logic [1:0] PSR_FN_CLR = 2'h1;
  localparam logic [1:0] PSR_FN_READ = 2'h2;
  localparam logic [31:0] PSR_REG_RESET = 32'h00000000;
  localparam logic [31:0] PSR_READ_ZERO = 32'h00000000;
endpackage : psr_pkg

//--- logic/psr_regmap.sv
`timescale 1ns/1ps
module psr_regmap
  import psr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  input wire logic [3:0] req_be,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic rsp_err,
  output logic win_sel,
  output logic [7:0] win_idx,
  output logic ic_sel,
  output logic [31:0] reg_value [psr_pkg::PSR_NREG]
);
  import psr_pkg::*;

  // ****************************************
  // Window decode
  // ****************************************
  logic in_region;
  logic ic_hit;
  logic ic_gap;
  logic [7:0] idx_raw;
  logic self_hit;
  logic other_hit;
  logic [13:0] win_off;
  logic [9:0] slot;
  logic [1:0] func;
  logic slot_ok;
  logic self_ok;
  logic req_err;
  logic [31:0] lane_mask;
  logic [31:0] wmask;

  // Region and slot index; offsets taken from the window base [R1] [R3] [R4]
  assign in_region = req_addr >= PSR_REGION_BASE; // [R1]
  assign idx_raw = 8'(req_addr[21:PSR_WIN_SHIFT] - PSR_WIN_FIRST); // [R3]
  assign ic_hit = req_addr[31:12] == PSR_IC_PAGE; // [R2]
  // Lower 12 Kbyte of the last slot stay unmapped to catch stray pointers
  assign ic_gap = in_region && (idx_raw == PSR_IC_WIN_IDX) && !ic_hit; // [R2]
  assign self_hit = in_region && (idx_raw == PSR_SELF_WIN_IDX);
  assign other_hit = in_region && !self_hit && !ic_gap;
  assign win_off = req_addr[13:0]; // [R3]
  assign slot = win_off[13:4];
  assign func = win_off[3:2]; // [R6]
  assign slot_ok = slot < 10'(PSR_NREG);
  // Fourth word of each triplet and unaligned addresses in the own window answer with an error
  assign self_ok = self_hit && slot_ok && (func != 2'h3) && (win_off[1:0] == 2'h0);
  assign req_err = !(self_ok || other_hit);

  // Little-endian lanes: byte enable i covers bits 8i+7..8i [R8]
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_lane
      assign lane_mask[8*b+7:8*b] = {8{req_be[b]}}; // [R8]
    end
  endgenerate
  assign wmask = req_wdata & lane_mask; // [R7]

  // ****************************************
  // Set / clear storage
  // ****************************************
  logic [31:0] store_reg [PSR_NREG];
  logic [31:0] store_next [PSR_NREG];
  logic set_hit [PSR_NREG];
  logic clr_hit [PSR_NREG];
  // Flat copy of every stored word, so checks can watch all triplets at once
  logic [32*PSR_NREG-1:0] store_flat;

  // One triplet per register: control, mode, data, status, interrupt [R5]
  genvar k;
  generate
    for (k = 0; k < PSR_NREG; k++)
    begin : g_reg
      assign set_hit[k] = req_valid && req_write && self_ok && (slot == 10'(k))
                          && (func == PSR_FN_SET); // [R6]
      assign clr_hit[k] = req_valid && req_write && self_ok && (slot == 10'(k))
                          && (func == PSR_FN_CLR); // [R6]
      // Writes at the read address fall through and keep the value [R9]
      assign store_next[k] = set_hit[k] ? (store_reg[k] | wmask)
                           : clr_hit[k] ? (store_reg[k] & ~wmask)
                           : store_reg[k]; // [R7]
      // Register storage
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          store_reg[k] <= PSR_REG_RESET;
        else
          store_reg[k] <= store_next[k];
      end
      assign reg_value[k] = store_reg[k];
      assign store_flat[32*k+31:32*k] = store_reg[k];
    end
  endgenerate

  // ****************************************
  // Response
  // ****************************************
  logic [31:0] rdata_next;
  logic rd_stored;

  // Only the read address returns the stored word; set and clear read zero [R9]
  assign rd_stored = self_ok && !req_write && (func == PSR_FN_READ);
  assign rdata_next = (req_valid && rd_stored) ? store_reg[slot[2:0]] : PSR_READ_ZERO;

  // Answer one cycle after each request; nothing stalls
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= PSR_READ_ZERO;
      rsp_err <= 1'b0;
      win_sel <= 1'b0;
      win_idx <= 8'h00;
      ic_sel <= 1'b0;
    end
    else
    begin
      rsp_valid <= req_valid;
      rsp_rdata <= rdata_next;
      rsp_err <= req_valid && req_err;
      win_sel <= req_valid && other_hit; // [R1]
      win_idx <= idx_raw;
      ic_sel <= req_valid && ic_hit; // [R2]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_set0;
    req_valid && req_write && self_ok && (slot == 10'h000) && (func == PSR_FN_SET);
  endsequence
  sequence s_clr0;
    req_valid && req_write && self_ok && (slot == 10'h000) && (func == PSR_FN_CLR);
  endsequence

  property p_win_sel;
    req_valid && other_hit |=> win_sel && (win_idx == $past(idx_raw)) && !rsp_err;
  endproperty
  a_win_sel: assert property (p_win_sel) // [R1]
    else $error("foreign window access not forwarded");

  property p_ic_gap;
    req_valid && ic_gap |=> rsp_err && !win_sel && !ic_sel;
  endproperty
  a_ic_gap: assert property (p_ic_gap) // [R2]
    else $error("gap below interrupt page not refused");

  property p_read_slot;
    req_valid && rd_stored |=> rsp_rdata == store_reg[$past(slot[2:0])];
  endproperty
  a_read_slot: assert property (p_read_slot) // [R3]
    else $error("read address returns wrong register");

  property p_outside;
    req_valid && !in_region |=> rsp_valid && rsp_err && !win_sel;
  endproperty
  a_outside: assert property (p_outside) // [R4]
    else $error("access outside peripheral region not refused");

  property p_set;
    s_set0 |=> ((store_reg[0] & $past(wmask)) == $past(wmask))
               && ((store_reg[0] & ~$past(wmask)) == ($past(store_reg[0]) & ~$past(wmask)));
  endproperty
  a_set: assert property (p_set) // [R6]
    else $error("set address did not set exactly the written ones");

  property p_clr;
    s_clr0 |=> ((store_reg[0] & $past(wmask)) == 32'h00000000)
               && ((store_reg[0] | $past(wmask)) == ($past(store_reg[0]) | $past(wmask)));
  endproperty
  a_clr: assert property (p_clr) // [R7]
    else $error("clear address did not clear exactly the written ones");

  property p_lane;
    s_set0 |=> ((store_reg[0] ^ $past(store_reg[0])) & ~$past(lane_mask)) == 32'h00000000;
  endproperty
  a_lane: assert property (p_lane) // [R8]
    else $error("disabled byte lanes were written");

  property p_rd_zero;
    req_valid && !req_write && self_ok && (func != PSR_FN_READ) |=> rsp_rdata == 32'h00000000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) // [R9]
    else $error("set or clear address read nonzero");

  property p_wr_read;
    req_valid && req_write && self_ok && (func == PSR_FN_READ) |=> $stable(store_flat);
  endproperty
  a_wr_read: assert property (p_wr_read) // [R9]
    else $error("write to read address changed storage");

  property p_regs;
    req_valid && self_ok |=> rsp_valid && !rsp_err;
  endproperty
  a_regs: assert property (p_regs) // [R5]
    else $error("own register access refused");

  // Refused writes and idle cycles must leave storage and strobes quiet
  property p_err_wr;
    req_valid && req_write && req_err |=> $stable(store_flat);
  endproperty
  a_err_wr: assert property (p_err_wr) // [R6]
    else $error("refused write changed storage");

  property p_no_req;
    !req_valid |=> !rsp_valid && !rsp_err && !win_sel && !ic_sel
      && (rsp_rdata == PSR_READ_ZERO);
  endproperty
  a_no_req: assert property (p_no_req) // [R4]
    else $error("response raised without a request");
endmodule : psr_regmap

//--- verification/psr_master_model.sv
`timescale 1ns/1ps
// ****************
// Peripheral bus master
// ****************
module psr_master_model
(
  input wire logic clk,
  output logic req_valid,
  output logic req_write,
  output logic [31:0] req_addr,
  output logic [31:0] req_wdata,
  output logic [3:0] req_be,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata,
  input wire logic rsp_err
);
  // Bus idle at time zero
  initial
  begin
    req_valid = 1'h0;
    req_write = 1'h0;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    req_be = 4'h0;
  end
  // One request cycle; answer taken one edge later; be[i] drives byte i
  task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] rd, output logic er, output logic vl);
    @(posedge clk);
    #1;
    req_valid = 1'h1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_be = be;
    @(posedge clk);
    #1;
    vl = rsp_valid;
    rd = rsp_rdata;
    er = rsp_err;
    req_valid = 1'h0;
    // Released address and data lines invert so stale values never pass as valid
    req_addr = ~a;
    req_wdata = ~d;
  endtask : access
endmodule : psr_master_model

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import psr_pkg::*;
  typedef struct packed
  {
    logic w;
    logic [31:0] a;
    logic [31:0] d;
    logic [3:0] be;
    logic err;
    logic [31:0] rd;
    logic [1:0] sel;
  } psr_row_t;
  logic clk, arst_n, req_valid, req_write, rsp_valid, rsp_err, win_sel, ic_sel, er, vl;
  logic [31:0] req_addr, req_wdata, rsp_rdata, rd;
  logic [3:0] req_be;
  logic [7:0] win_idx;
  logic [31:0] reg_value [PSR_NREG];
  int fail_count = 0;
  int total_checks = 0;
  // Set, clear, read-back, lanes, refused and foreign windows
  psr_row_t rows [19] = '{
    '{1'h1, 32'hFFD00010, 32'h0000000F, 4'hF, 1'h0, 32'h0, 2'h0},
    '{1'h0, 32'hFFD00018, 32'h0, 4'h0, 1'h0, 32'h0000000F, 2'h0},
    '{1'h1, 32'hFFD00014, 32'h00000005, 4'hF, 1'h0, 32'h0, 2'h0},
    '{1'h0, 32'hFFD00018, 32'h0, 4'h0, 1'h0, 32'h0000000A, 2'h0},
    '{1'h1, 32'hFFD00018, 32'hFFFFFFFF, 4'hF, 1'h0, 32'h0, 2'h0},
    '{1'h0, 32'hFFD00018, 32'h0, 4'h0, 1'h0, 32'h0000000A, 2'h0},
    '{1'h0, 32'hFFD00010, 32'h0, 4'h0, 1'h0, 32'h0, 2'h0},
    '{1'h0, 32'hFFD00014, 32'h0, 4'h0, 1'h0, 32'h0, 2'h0},
    '{1'h1, 32'hFFD00000, 32'hFFFFFFFF, 4'h2, 1'h0, 32'h0, 2'h0},
    '{1'h0, 32'hFFD00008, 32'h0, 4'h0, 1'h0, 32'h0000FF00, 2'h0},
    '{1'h1, 32'hFFD00040, 32'h80000000, 4'hF, 1'h0, 32'h0, 2'h0},
    '{1'h0, 32'hFFD00048, 32'h0, 4'h0, 1'h0, 32'h80000000, 2'h0},
    '{1'h1, 32'hFFD0001C, 32'hFFFFFFFF, 4'hF, 1'h1, 32'h0, 2'h0},
    '{1'h1, 32'hFFD00050, 32'hFFFFFFFF, 4'hF, 1'h1, 32'h0, 2'h0},
    '{1'h0, 32'hFFD00019, 32'h0, 4'h0, 1'h1, 32'h0, 2'h0},
    '{1'h0, 32'hFFCFFFFC, 32'h0, 4'h0, 1'h1, 32'h0, 2'h0},
    '{1'h0, 32'hFFFFE000, 32'h0, 4'h0, 1'h1, 32'h0, 2'h0},
    '{1'h0, 32'hFFFFF000, 32'h0, 4'h0, 1'h0, 32'h0, 2'h3},
    '{1'h0, 32'hFFD04000, 32'h0, 4'h0, 1'h0, 32'h0, 2'h2}};
  psr_regmap psr_regmap_i (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .win_sel(win_sel),
    .win_idx(win_idx), .ic_sel(ic_sel), .reg_value(reg_value));
  psr_master_model psr_master_model_i (.clk(clk), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err));
  // ****************
  // Clock, checks and verdict
  // ****************
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  // Hang guard, far beyond the fifty or so cycles the run needs
  initial
  begin
    #40000;
    fail_count++;
    end_sim();
  end
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    arst_n = 1'h0;
    repeat (6) @(posedge clk);
    #1 arst_n = 1'h1;
    foreach (rows[i])
    begin
      psr_master_model_i.access(rows[i].w, rows[i].a, rows[i].d, rows[i].be, rd, er, vl);
      chk("rsp_valid", {31'h0, vl}, 32'h1);
      chk("rsp_err", {31'h0, er}, {31'h0, rows[i].err});
      chk("rsp_rdata", rd, rows[i].rd);
      chk("win_ic_sel", {30'h0, win_sel, ic_sel}, {30'h0, rows[i].sel});
    end
    chk("win_idx", {24'h0, win_idx}, 32'h1);
    chk("reg1", reg_value[1], 32'h0000000A);
    chk("reg0", reg_value[0], 32'h0000FF00);
    chk("reg4", reg_value[4], 32'h80000000);
    chk("reg2", reg_value[2], PSR_REG_RESET);
    chk("reg3", reg_value[3], PSR_REG_RESET);
    // Reset in mid-run clears the stored words
    #1 arst_n = 1'h0;
    repeat (2) @(posedge clk);
    chk("reg1_in_reset", reg_value[1], PSR_REG_RESET);
    #1 arst_n = 1'h1;
    psr_master_model_i.access(1'h0, 32'hFFD00018, 32'h0, 4'h0, rd, er, vl);
    chk("reg1_after_reset", rd, PSR_REG_RESET);
    chk("rsp_valid_after_reset", {31'h0, vl}, 32'h1);
    chk("rsp_err_after_reset", {31'h0, er}, 32'h0);
    chk("win_ic_sel_after_reset", {30'h0, win_sel, ic_sel}, 32'h0);
    end_sim();
  end
endmodule : tb_top
